// file: hdl/dcirq_pkg.sv
// Package for the disk controller interrupt, control word and timeout block.
// Assumes a single 25 MHz core clock standing in for the phase-two clock.
package dcirq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ   = 25000000;
  localparam int unsigned TIMEOUT_MS    = 150;
  localparam int unsigned TIMEOUT_CYCLES =
    (CLK_FREQ_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned TIMER_WIDTH   = 23;

  // ----------------------------------------------------------------
  // Control word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned CW_FUNC0      = 1;
  localparam int unsigned CW_FUNC1      = 2;
  localparam int unsigned CW_FUNC2      = 3;
  localparam int unsigned CW_INT_EN     = 6;
  localparam int unsigned CW_READY      = 7;
  localparam int unsigned CW_DSEL_LO    = 8;
  localparam int unsigned CW_DSEL_HI    = 9;
  localparam int unsigned CW_ATTN_CLR0  = 16;
  localparam int unsigned CW_SKIP_INH   = 22;
  localparam int unsigned CW_SKIP_FLAG  = 23;
  localparam int unsigned CW_MAINTENANCE_BIT      = 25;
  localparam int unsigned CW_AUTO_SKIP  = 27;
  localparam int unsigned CW_LARGE_FMT  = 28;
  localparam int unsigned CW_SPARE29    = 29;
  localparam int unsigned NUM_DRIVES    = 4;

  // Status word positions for block state
  localparam int unsigned SW_OP_INCOMP  = 14;
  localparam int unsigned SW_DATA_LATE  = 12;
  localparam int unsigned SW_INT_PEND   = 15;
  localparam int unsigned SW_TIMEOUT    = 10;
  localparam int unsigned SW_ATTN0      = 16;

  // ----------------------------------------------------------------
  // Reset values and command codes
  // ----------------------------------------------------------------
  localparam logic [31:0] CW_RESET      = 32'h0000_0080;
  localparam logic [2:0]  CMD_XFER_REQ  = 3'h4;
  localparam logic [2:0]  CMD_SET_READY = 3'h1;
  localparam logic [2:0]  CMD_SET_OPI   = 3'h2;
  localparam logic [2:0]  CMD_SET_DLT   = 3'h3;
  localparam logic [8:0]  JAM_ADDR      = 9'h1ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] funcCode;
    logic       maintenance;
    logic       autoSkipInhibit;
    logic       largeDriveFormat;
    logic       interruptEnable;
    logic [1:0] driveSelect;
    logic       skipInhibit;
    logic       skipFlag;
    logic       spare29;
  } dcirq_ctl_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic       setInterrupt;
    logic       retriggerTimer;
    logic [3:0] setAttention;
  } dcirq_useq_t;

endpackage

// file: hdl/dcirq_func_timer.sv
// Function timer: retriggerable down-counter of core clock cycles.
// Assumes trigger and retrigger are one-cycle pulses in the core clock.
`timescale 1ns/1ns
module dcirq_func_timer #(
  parameter int unsigned RELOAD = dcirq_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic inhibit,
  // Status
  output logic      expired
);

  logic [dcirq_pkg::TIMER_WIDTH-1:0] count_r;
  logic                              running_r;

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || inhibit) begin
      count_r   <= '0;
      running_r <= 1'b0;
    end else if (start) begin
      count_r   <= dcirq_pkg::TIMER_WIDTH'(RELOAD - 1);
      running_r <= 1'b1;
    end else if (running_r) begin
      if (count_r == '0) begin
        running_r <= 1'b0;
      end else begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // One-cycle pulse at expiry; maintenance inhibit masks it
  always_ff @(posedge clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= running_r && count_r == '0 && !start && !inhibit;
    end
  end

endmodule

// file: hdl/dcirq_attention.sv
// Per-drive attention flags with host clears and deassertion events.
// Assumes set pulses come from the drive status monitor sequencer.
`timescale 1ns/1ns
module dcirq_attention (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Set and clear
  input  wire logic [3:0] setAttention,
  input  wire logic [3:0] hostClear,
  // Status
  output logic      [3:0] attention,
  output logic      [3:0] attnDropped
);

  genvar d;
  generate
    for (d = 0; d < dcirq_pkg::NUM_DRIVES; d++) begin : gDrive
      // Only host writes or init clear; set wins over clear
      always_ff @(posedge clk) begin
        if (rst) begin
          attention[d] <= 1'b0;
        end else if (setAttention[d]) begin
          attention[d] <= 1'b1;
        end else if (hostClear[d]) begin
          attention[d] <= 1'b0;
        end
      end
      assign attnDropped[d] = attention[d] && hostClear[d] &&
                              !setAttention[d];
    end
  endgenerate

endmodule

// file: hdl/dcirq_core.sv
// Function
// - Interrupt after function end or status change
// - Transfer request per completed sector
// - Interrupt enable clear blocks bus interrupt
// - Set pulse or attention drop requests interrupt
// - Interrupt flip-flop sets and holds itself
// - Host clear op resets interrupt flip-flop
// - Command code 100 sets transfer request
// - Grant or init clears transfer request
// - Control write captures selected bits
// - Registered bits echoed in status word
// - Bits 16-19 clear drive attention flags
// - Registered bits feed the microsequencer
// - Maintenance asserts write inhibit, stops timeout
// - Bits 22 and 23 held for skip logic
// - Bit 07 is ready; low starts function
// - Starting write clears both fault flags
// - Function start triggers 150 ms timer
// - Expiry while busy sets timeout, fault
// - Timeout jams 1FF, blocks buffer, CPU clock
// - Jam microcode sets ready, requests interrupt
// - Retrigger pulse grants another 150 ms
// - Attention cleared only by host or init
//
// Interrupt, control word and timeout logic of a disk controller.
// Assumes the CPU port and microsequencer are synchronous to clk.
`timescale 1ns/1ns
module dcirq_core #(
  parameter int unsigned TIMER_RELOAD = dcirq_pkg::TIMEOUT_CYCLES
) (
  // Clock and controller init
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Host CPU port
  input  wire logic                   controlWriteStrobe,
  input  wire logic [31:0]            controlWord,
  input  wire logic                   clearInterruptPortOp,
  input  wire logic                   transferGrant,
  output logic      [31:0]            controlStatusWord,
  output logic                        busInterruptRequest,
  output logic                        sectorTransferRequest,
  // Microsequencer
  input  wire dcirq_pkg::dcirq_useq_t useq,
  output dcirq_pkg::dcirq_ctl_t       ctl,
  output logic                        controllerReady,
  output logic                        jamActive,
  output logic      [8:0]             jamAddress,
  output logic                        bufferBlock,
  output logic                        selectCpuClock,
  // Drive side
  output logic                        writeInhibit,
  output logic                        opIncomplete,
  output logic                        dataLate,
  output logic                        timeoutFlag,
  output logic      [3:0]             driveAttention
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       startFunction;
  logic       timerExpired;
  logic       timerStart;
  logic       interruptCause;
  logic [3:0] attnFlags;
  logic [3:0] attnDropped;
  logic [3:0] attnClear;
  logic       cmdSetReady;

  // Writing ready low starts a function
  assign startFunction = controlWriteStrobe &&
                         !controlWord[dcirq_pkg::CW_READY];
  assign attnClear     = controlWriteStrobe ?
    controlWord[dcirq_pkg::CW_ATTN_CLR0 +: 4] : 4'h0;
  assign cmdSetReady   = useq.cmd == dcirq_pkg::CMD_SET_READY;
  assign timerStart    = startFunction || useq.retriggerTimer;

  // ----------------------------------------------------------------
  // Control word holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= '0;
    end else if (controlWriteStrobe) begin
      ctl.funcCode         <= controlWord[dcirq_pkg::CW_FUNC2:
                                          dcirq_pkg::CW_FUNC0];
      ctl.interruptEnable  <= controlWord[dcirq_pkg::CW_INT_EN];
      ctl.driveSelect      <= controlWord[dcirq_pkg::CW_DSEL_HI:
                                          dcirq_pkg::CW_DSEL_LO];
      ctl.maintenance      <= controlWord[dcirq_pkg::CW_MAINTENANCE_BIT];
      ctl.autoSkipInhibit  <= controlWord[dcirq_pkg::CW_AUTO_SKIP];
      ctl.largeDriveFormat <= controlWord[dcirq_pkg::CW_LARGE_FMT];
      ctl.spare29          <= controlWord[dcirq_pkg::CW_SPARE29];
      ctl.skipInhibit      <= controlWord[dcirq_pkg::CW_SKIP_INH];
      ctl.skipFlag         <= controlWord[dcirq_pkg::CW_SKIP_FLAG];
    end
  end

  // Write inhibit follows the stored maintenance bit
  always_ff @(posedge clk) begin
    if (rst) begin
      writeInhibit <= 1'b0;
    end else if (controlWriteStrobe) begin
      writeInhibit <= controlWord[dcirq_pkg::CW_MAINTENANCE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Ready bit
  // ----------------------------------------------------------------
  // Microcode set wins over a simultaneous host write
  always_ff @(posedge clk) begin
    if (rst) begin
      controllerReady <= dcirq_pkg::CW_RESET[dcirq_pkg::CW_READY];
    end else if (cmdSetReady) begin
      controllerReady <= 1'b1;
    end else if (controlWriteStrobe) begin
      controllerReady <= controlWord[dcirq_pkg::CW_READY];
    end
  end

  // ----------------------------------------------------------------
  // Function timer
  // ----------------------------------------------------------------
  dcirq_func_timer #(
    .RELOAD (TIMER_RELOAD)
  ) uTimer (
    .clk     (clk),
    .rst     (rst),
    .start   (timerStart),
    .inhibit (writeInhibit),
    .expired (timerExpired)
  );

  // Timeout only when ready still low at expiry
  always_ff @(posedge clk) begin
    if (rst) begin
      timeoutFlag <= 1'b0;
    end else if (timerExpired && !controllerReady) begin
      timeoutFlag <= 1'b1;
    end else if (startFunction) begin
      timeoutFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  // Microcode sets win over the start-of-function clear; the timeout set does not
  always_ff @(posedge clk) begin
    if (rst) begin
      opIncomplete <= 1'b0;
    end else if ((timeoutFlag && !startFunction) ||
                 useq.cmd == dcirq_pkg::CMD_SET_OPI) begin
      opIncomplete <= 1'b1;
    end else if (startFunction) begin
      opIncomplete <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dataLate <= 1'b0;
    end else if (useq.cmd == dcirq_pkg::CMD_SET_DLT) begin
      dataLate <= 1'b1;
    end else if (startFunction) begin
      dataLate <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Jam control
  // ----------------------------------------------------------------
  // Jam holds until microcode at 1FF reports ready again
  always_ff @(posedge clk) begin
    if (rst) begin
      jamActive      <= 1'b0;
      bufferBlock    <= 1'b0;
      selectCpuClock <= 1'b0;
    end else if (timerExpired && !controllerReady) begin
      jamActive      <= 1'b1;
      bufferBlock    <= 1'b1;
      selectCpuClock <= 1'b1;
    end else if (cmdSetReady) begin
      jamActive      <= 1'b0;
      bufferBlock    <= 1'b0;
      selectCpuClock <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      jamAddress <= 9'h000;
    end else begin
      jamAddress <= (timerExpired && !controllerReady) ?
                    dcirq_pkg::JAM_ADDR : 9'h000;
    end
  end

  // ----------------------------------------------------------------
  // Drive attention flags
  // ----------------------------------------------------------------
  dcirq_attention uAttn (
    .clk          (clk),
    .rst          (rst),
    .setAttention (useq.setAttention),
    .hostClear    (attnClear),
    .attention    (attnFlags),
    .attnDropped  (attnDropped)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      driveAttention <= 4'h0;
    end else begin
      driveAttention <= attnFlags;
    end
  end

  // ----------------------------------------------------------------
  // Bus interrupt flip-flop
  // ----------------------------------------------------------------
  assign interruptCause = ctl.interruptEnable &&
                          (useq.setInterrupt || |attnDropped);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busInterruptRequest <= 1'b0;
    end else if (interruptCause) begin
      busInterruptRequest <= 1'b1;
    end else if (clearInterruptPortOp || !ctl.interruptEnable) begin
      busInterruptRequest <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sector transfer request latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sectorTransferRequest <= 1'b0;
    end else if (useq.cmd == dcirq_pkg::CMD_XFER_REQ) begin
      sectorTransferRequest <= 1'b1;
    end else if (transferGrant) begin
      sectorTransferRequest <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status word readback
  // ----------------------------------------------------------------
  // Attention bits read in place of the write-only clear bits
  always_ff @(posedge clk) begin
    if (rst) begin
      controlStatusWord <= dcirq_pkg::CW_RESET;
    end else begin
      controlStatusWord <= '0;
      controlStatusWord[dcirq_pkg::CW_FUNC2:dcirq_pkg::CW_FUNC0]
        <= ctl.funcCode;
      controlStatusWord[dcirq_pkg::CW_INT_EN]    <= ctl.interruptEnable;
      controlStatusWord[dcirq_pkg::CW_READY]     <= controllerReady;
      controlStatusWord[dcirq_pkg::CW_DSEL_HI:dcirq_pkg::CW_DSEL_LO]
        <= ctl.driveSelect;
      controlStatusWord[dcirq_pkg::SW_TIMEOUT]   <= timeoutFlag;
      controlStatusWord[dcirq_pkg::SW_DATA_LATE] <= dataLate;
      controlStatusWord[dcirq_pkg::SW_OP_INCOMP] <= opIncomplete;
      controlStatusWord[dcirq_pkg::SW_INT_PEND]  <= busInterruptRequest;
      controlStatusWord[dcirq_pkg::SW_ATTN0 +: 4] <= attnFlags;
      controlStatusWord[dcirq_pkg::CW_SKIP_INH]  <= ctl.skipInhibit;
      controlStatusWord[dcirq_pkg::CW_SKIP_FLAG] <= ctl.skipFlag;
      controlStatusWord[dcirq_pkg::CW_MAINTENANCE_BIT]     <= ctl.maintenance;
      controlStatusWord[dcirq_pkg::CW_AUTO_SKIP] <= ctl.autoSkipInhibit;
      controlStatusWord[dcirq_pkg::CW_LARGE_FMT] <= ctl.largeDriveFormat;
      controlStatusWord[dcirq_pkg::CW_SPARE29]   <= ctl.spare29;
    end
  end

endmodule

// file: tb/dcirq_core_sva.sv
// Checker for the interrupt, control word and timeout block.
// Assumes it is bound to dcirq_core and sees only its ports.
`timescale 1ns/1ns
module dcirq_core_sva #(
  parameter int unsigned TIMER_RELOAD = dcirq_pkg::TIMEOUT_CYCLES
) (
  // Clock and init
  input wire logic                   clk,
  input wire logic                   rst,
  // Host port
  input wire logic                   controlWriteStrobe,
  input wire logic [31:0]            controlWord,
  input wire logic                   clearInterruptPortOp,
  input wire logic                   transferGrant,
  input wire logic [31:0]            controlStatusWord,
  input wire logic                   busInterruptRequest,
  input wire logic                   sectorTransferRequest,
  // Microsequencer and drive side
  input wire dcirq_pkg::dcirq_useq_t useq,
  input wire dcirq_pkg::dcirq_ctl_t  ctl,
  input wire logic                   controllerReady,
  input wire logic                   jamActive,
  input wire logic [8:0]             jamAddress,
  input wire logic                   writeInhibit,
  input wire logic                   opIncomplete,
  input wire logic                   dataLate,
  input wire logic                   timeoutFlag,
  input wire logic [3:0]             driveAttention
);
  // ------
  // Cycles since the last function start or retrigger, saturating; 0 until the first
  // ------
  logic [23:0] sinceStart_r;
  logic        startEv;
  assign startEv = (controlWriteStrobe && !controlWord[7]) ||
                   useq.retriggerTimer;
  always_ff @(posedge clk) begin
    if (rst) begin
      sinceStart_r <= '0;
    end else if (startEv) begin
      sinceStart_r <= 24'h1;
    end else if (sinceStart_r != '0 && sinceStart_r != '1) begin
      sinceStart_r <= sinceStart_r + 24'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  irq_blocked_a: assert property (
    !ctl.interruptEnable && !$past(ctl.interruptEnable)
    |-> !busInterruptRequest) else $error("interrupt while disabled");
  irq_set_a: assert property (
    ctl.interruptEnable && useq.setInterrupt && !controlWriteStrobe
    |=> busInterruptRequest) else $error("interrupt not raised");
  attn_irq_a: assert property (
    controlWriteStrobe && ctl.interruptEnable && controlWord[6] &&
    |(controlWord[19:16] & driveAttention)
    |-> ##[1:2] busInterruptRequest) else $error("attention drop missed");
  irq_hold_a: assert property (
    busInterruptRequest && ctl.interruptEnable && !clearInterruptPortOp &&
    !controlWriteStrobe |=> busInterruptRequest)
    else $error("interrupt dropped alone");
  irq_clear_a: assert property (
    clearInterruptPortOp && !useq.setInterrupt && !controlWriteStrobe &&
    !$past(controlWriteStrobe) |=> !busInterruptRequest)
    else $error("interrupt not cleared");
  xfer_set_a: assert property (
    useq.cmd == dcirq_pkg::CMD_XFER_REQ |=> sectorTransferRequest)
    else $error("transfer request not set");
  xfer_hold_a: assert property (
    sectorTransferRequest && !transferGrant |=> sectorTransferRequest)
    else $error("transfer request dropped alone");
  xfer_grant_a: assert property (
    transferGrant && useq.cmd != dcirq_pkg::CMD_XFER_REQ
    |=> !sectorTransferRequest) else $error("grant did not clear");
  ctl_load_a: assert property (
    controlWriteStrobe |=> ctl.funcCode == $past(controlWord[3:1]) &&
    ctl.driveSelect == $past(controlWord[9:8]) &&
    writeInhibit == $past(controlWord[25])) else $error("bad capture");
  echo_a: assert property (
    controlWriteStrobe ##1 !controlWriteStrobe
    |=> (controlStatusWord & 32'h3ac0034e) ==
        ($past(controlWord, 2) & 32'h3ac0034e)) else $error("bad echo");
  ready_a: assert property (
    controlWriteStrobe && useq.cmd != dcirq_pkg::CMD_SET_READY
    |=> controllerReady == $past(controlWord[7])) else $error("bad ready");
  fault_clr_a: assert property (
    controlWriteStrobe && !controlWord[7] && useq.cmd == 3'h0
    |=> !opIncomplete && !dataLate)
    else $error("faults kept on start");
  early_a: assert property (
    $rose(timeoutFlag) |-> sinceStart_r >= TIMER_RELOAD)
    else $error("timeout too early");
  late_a: assert property (
    sinceStart_r == TIMER_RELOAD + 4 && !controllerReady && !writeInhibit
    |-> timeoutFlag) else $error("timeout missing");
  opi_a: assert property (
    $rose(timeoutFlag) && !controlWriteStrobe |=> opIncomplete)
    else $error("timeout without fault");
  jam_a: assert property (
    $rose(timeoutFlag) |-> jamActive && jamAddress == dcirq_pkg::JAM_ADDR)
    else $error("no jam on timeout");
  attn_clr_a: assert property (
    controlWriteStrobe && controlWord[16] && !useq.setAttention[0]
    ##1 !useq.setAttention[0] |=> !driveAttention[0])
    else $error("attention not cleared");
  attn_keep_a: assert property (
    !controlWriteStrobe && !$past(controlWriteStrobe)
    |=> ($past(driveAttention) & ~driveAttention) == 4'h0)
    else $error("attention cleared without host");
endmodule

bind dcirq_core dcirq_core_sva #(.TIMER_RELOAD(TIMER_RELOAD)) chk (
  .clk(clk), .rst(rst), .controlWriteStrobe(controlWriteStrobe),
  .controlWord(controlWord), .clearInterruptPortOp(clearInterruptPortOp),
  .transferGrant(transferGrant), .controlStatusWord(controlStatusWord),
  .busInterruptRequest(busInterruptRequest),
  .sectorTransferRequest(sectorTransferRequest), .useq(useq), .ctl(ctl),
  .controllerReady(controllerReady), .jamActive(jamActive),
  .jamAddress(jamAddress), .writeInhibit(writeInhibit),
  .opIncomplete(opIncomplete), .dataLate(dataLate),
  .timeoutFlag(timeoutFlag), .driveAttention(driveAttention));

// file: tb/dcirq_useq_model.sv
// Microsequencer model: passes bench requests, answers a jam.
// Assumes requests change at the falling edge, like the bench.
`timescale 1ns/1ns
module dcirq_useq_model (
  // Clock and init
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Bench requests and reply delay
  input  wire dcirq_pkg::dcirq_useq_t req,
  input  wire logic [3:0]             lag,
  // Block side
  input  wire logic                   jamActive,
  output dcirq_pkg::dcirq_useq_t      useq
);
  localparam dcirq_pkg::dcirq_useq_t JAM_REPLY =
    '{cmd: dcirq_pkg::CMD_SET_READY, setInterrupt: 1'b1, default: '0};
  logic [3:0] waitCnt;
  logic       answer;
  // Lag lets the jam routine reply promptly or slowly
  always @(negedge clk) begin
    if (rst || !jamActive) begin
      waitCnt <= 4'h0;
      answer  <= 1'b0;
    end else if (waitCnt < lag) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      answer <= 1'b1;
    end
  end
  assign useq = answer ? JAM_REPLY : req;
endmodule

// file: tb/tb_top.sv
// Bench for the interrupt, control word and timeout block.
// Assumes the microsequencer model drives the useq port.
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned RELOAD = 50;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   strobe = 1'b0;
  logic [31:0]            word = 32'h0;
  logic                   clrOp = 1'b0;
  logic                   grant = 1'b0;
  logic [3:0]             lag = 4'h0;
  dcirq_pkg::dcirq_useq_t req = '0;
  dcirq_pkg::dcirq_useq_t useq;
  dcirq_pkg::dcirq_ctl_t  ctl;
  logic [31:0]            csw;
  logic                   irq, xfer, rdy, jam, bufBlk, cpuClk;
  logic                   wrInh, operation_incomplete_flag, data_late_flag, tmo;
  logic [8:0]             jamAdr;
  logic [3:0]             attn;
  logic [31:0]            w;
  int                     fail_count = 0;
  int                     n_checks = 0;
  int                     cycles = 0;

  always #20 clk = ~clk;

  dcirq_core #(.TIMER_RELOAD(RELOAD)) DUT (
    .clk(clk), .rst(rst), .controlWriteStrobe(strobe), .controlWord(word),
    .clearInterruptPortOp(clrOp), .transferGrant(grant),
    .controlStatusWord(csw), .busInterruptRequest(irq),
    .sectorTransferRequest(xfer), .useq(useq), .ctl(ctl),
    .controllerReady(rdy), .jamActive(jam), .jamAddress(jamAdr),
    .bufferBlock(bufBlk), .selectCpuClock(cpuClk), .writeInhibit(wrInh),
    .opIncomplete(operation_incomplete_flag), .dataLate(data_late_flag), .timeoutFlag(tmo),
    .driveAttention(attn));
  dcirq_useq_model UM (.clk(clk), .rst(rst), .req(req), .lag(lag),
    .jamActive(jam), .useq(useq));

  // ------
  // Tasks
  // ------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [31:0] v);
    strobe = 1'b1;
    word = v;
    cyc(1);
    strobe = 1'b0;
  endtask
  task automatic us(input dcirq_pkg::dcirq_useq_t u);
    req = u;
    cyc(1);
    req = '0;
  endtask
  task automatic clearIrq();
    clrOp = 1'b1;
    cyc(1);
    clrOp = 1'b0;
  endtask
  function automatic dcirq_pkg::dcirq_ctl_t ctlOf(input logic [31:0] v);
    return {v[3:1], v[25], v[27], v[28], v[6], v[9:8], v[22], v[23], v[29]};
  endfunction

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    w = $urandom(32'h70f8acfa);
    cyc(2);
    rst = 1'b0;
    check(csw, dcirq_pkg::CW_RESET);
    check({irq, xfer, rdy, tmo, operation_incomplete_flag}, 5'b00100);
    // Back-to-back writes, the second one wins
    for (int i = 0; i < 12; i++) begin
      strobe = 1'b1;
      word = $urandom;
      cyc(1);
      word = $urandom | 32'h80;
      w = word;
      cyc(1);
      strobe = 1'b0;
      cyc(1);
      check(ctl, ctlOf(w));
      check(wrInh, w[25]);
      check(rdy, 1'b1);
      check(csw & 32'h3ac0034e, w & 32'h3ac0034e);
    end
    $display("test control word finished");
    wr(32'hc0);
    us('{setInterrupt: 1'b1, default: '0});
    check(irq, 1'b1);
    cyc(3);
    check(irq, 1'b1);
    clearIrq();
    check(irq, 1'b0);
    wr(32'h80);
    us('{setInterrupt: 1'b1, default: '0});
    cyc(1);
    check(irq, 1'b0);
    $display("test interrupt finished");
    us('{cmd: dcirq_pkg::CMD_XFER_REQ, default: '0});
    cyc(2);
    check(xfer, 1'b1);
    grant = 1'b1;
    cyc(1);
    grant = 1'b0;
    check(xfer, 1'b0);
    us('{cmd: dcirq_pkg::CMD_XFER_REQ, default: '0});
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    check({xfer, irq, tmo, rdy}, 4'b0001);
    $display("test transfer finished");
    wr(32'hc0);
    us('{setAttention: 4'hf, default: '0});
    cyc(1);
    check(attn, 4'hf);
    wr(32'h000300c0);
    cyc(2);
    check(attn, 4'hc);
    check(irq, 1'b1);
    clearIrq();
    $display("test attention finished");
    us('{cmd: dcirq_pkg::CMD_SET_OPI, default: '0});
    cyc(1);
    us('{cmd: dcirq_pkg::CMD_SET_DLT, default: '0});
    check({operation_incomplete_flag, data_late_flag}, 2'b11);
    wr(32'h02000000);
    cyc(1);
    check({operation_incomplete_flag, data_late_flag, wrInh}, 3'b001);
    cyc(RELOAD + 10);
    check(tmo, 1'b0);
    wr(32'h80);
    $display("test maintenance finished");
    // Prompt reply first, then a slow one
    for (int i = 0; i < 2; i++) begin
      lag = (i == 0) ? 4'h0 : 4'($urandom_range(7, 2));
      wr(32'h40 | ($urandom & 32'he));
      cyc(20);
      check(operation_incomplete_flag, 1'b0);
      us('{retriggerTimer: 1'b1, default: '0});
      cyc(RELOAD - 4);
      check(tmo, 1'b0);
      for (int k = 0; k < 20 && !jam; k++) cyc(1);
      check({tmo, jamAdr, bufBlk, cpuClk},
            {1'b1, dcirq_pkg::JAM_ADDR, 2'b11});
      cyc(1);
      check(operation_incomplete_flag, 1'b1);
      for (int k = 0; k < 12 && !rdy; k++) cyc(1);
      cyc(1);
      check({irq, jam, rdy}, 3'b101);
      clearIrq();
    end
    $display("test timeout finished");
    test_done();
  end
endmodule
